/* common/dtc_pkg.sv */
package dtc_pkg;
	localparam int NUM_CH = 8;
	localparam int NUM_LANES = 4;
	localparam int WORD_W = 10;
	localparam int LOW_W = 8;
	localparam int HIGH_W = 2;
	localparam int REG_W = 16;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 8;
	localparam int BS_W = 3;
	localparam int PRBS_W = 15;
	localparam int PRBS_TAP_A = 14;
	localparam int PRBS_TAP_B = 13;

	// Register addresses
	localparam logic [ADDR_W-1:0] ADDR_BLACKCAL = 8'h80;
	localparam logic [ADDR_W-1:0] ADDR_CAL_FAULT = 8'h89;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_A = 8'h8A;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_B = 8'h8B;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_C = 8'h8C;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_ONES = 8'h8D;
	localparam logic [ADDR_W-1:0] ADDR_TEST_CFG = 8'h90;
	localparam logic [ADDR_W-1:0] ADDR_PAT_LOW01 = 8'h92;
	localparam logic [ADDR_W-1:0] ADDR_PAT_LOW23 = 8'h93;
	localparam logic [ADDR_W-1:0] ADDR_PAT_HIGH = 8'h96;

	// Reset and fixed values
	localparam logic [REG_W-1:0] BLACKCAL_RST = 16'h4008;
	localparam logic [REG_W-1:0] TEST_CFG_RST = 16'h0000;
	localparam logic [REG_W-1:0] PAT_LOW01_RST = 16'h0100;
	localparam logic [REG_W-1:0] PAT_LOW23_RST = 16'h0302;
	localparam logic [REG_W-1:0] PAT_HIGH_RST = 16'h0000;
	localparam logic [REG_W-1:0] RSVD_ONES_VAL = 16'hFFFF;
	localparam logic [REG_W-1:0] RSVD_ZERO_VAL = 16'h0000;
	localparam logic [PRBS_W-1:0] PRBS_SEED = 15'h7FFF;

	// Field positions and widths
	localparam int TC_PAT_EN = 0;
	localparam int TC_INC = 1;
	localparam int TC_PRBS = 2;
	localparam int TC_FRAME = 3;
	localparam int TC_W = 4;
	localparam int BS_LSB = 8;
	localparam int HIGH_FIELD_W = NUM_LANES * HIGH_W;
endpackage

/* rtl/dtc_lane_gen.sv */
`timescale 1ns/1ps
module dtc_lane_gen
#(
	parameter logic [dtc_pkg::PRBS_W-1:0] SEED = dtc_pkg::PRBS_SEED
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic active,
	input wire logic incMode,
	input wire logic prbsMode,
	input wire logic advance,
	input wire logic [dtc_pkg::WORD_W-1:0] loadValue,
	output logic [dtc_pkg::WORD_W-1:0] word
);
	import dtc_pkg::*;

	logic [WORD_W-1:0] count_reg;
	logic [PRBS_W-1:0] lfsr_reg;

	// Ramp restarts from the programmed value whenever not ramping
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			count_reg <= '0;
		else if (!active || !incMode)
			count_reg <= loadValue;
		else if (advance)
			count_reg <= WORD_W'(count_reg + 1'b1);
	end

	// One LFSR step per emitted word
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			lfsr_reg <= SEED;
		else if (prbsMode && advance)
			lfsr_reg <= {lfsr_reg[PRBS_W-2:0], lfsr_reg[PRBS_TAP_A] ^ lfsr_reg[PRBS_TAP_B]};
	end

	// Constant mode shows the programmed value at once, so a rewrite is seen next word
	assign word = prbsMode ? lfsr_reg[WORD_W-1:0] : (incMode ? count_reg : loadValue);

	prbs_live_a: assert property (@(posedge clk) disable iff (!rstn) prbsMode |-> lfsr_reg != '0) else $error("PRBS state collapsed to zero");
endmodule

/* rtl/dtc_test_cal_status.sv */
`timescale 1ns/1ps
module dtc_test_cal_status
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [dtc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [dtc_pkg::REG_W-1:0] regWrData,
	output logic [dtc_pkg::REG_W-1:0] regRdData,
	input wire logic blackCalStart,
	input wire logic blackCalEnd,
	input wire logic [dtc_pkg::NUM_CH-1:0] blackSample,
	input wire logic [dtc_pkg::NUM_LANES*dtc_pkg::WORD_W-1:0] pixData,
	input wire logic pixValid,
	input wire logic frameIn,
	input wire logic lineIn,
	output logic [dtc_pkg::NUM_LANES*dtc_pkg::WORD_W-1:0] dataOut,
	output logic dataValid,
	output logic frameOut,
	output logic lineOut
);
	import dtc_pkg::*;

	logic [REG_W-1:0] blackCal_reg;
	logic [TC_W-1:0] testCfg_reg;
	logic [REG_W-1:0] patLow01_reg;
	logic [REG_W-1:0] patLow23_reg;
	logic [HIGH_FIELD_W-1:0] patHigh_reg;
	logic [NUM_CH-1:0] calFault_reg;
	logic [NUM_CH-1:0] calFault_next;
	logic [CNT_W-1:0] sampleCnt_reg [NUM_CH];
	logic [CNT_W-1:0] reqCount;
	logic [REG_W-1:0] rdValue;
	logic [NUM_LANES*WORD_W-1:0] patWords;
	logic [NUM_LANES*WORD_W-1:0] constWords;
	logic [2*REG_W-1:0] lowBytes;
	logic cfgPatEn;
	logic cfgInc;
	logic cfgPrbs;
	logic cfgFrame;
	logic patActive;
	logic wordSlot;

	function automatic logic isWrite(input logic [ADDR_W-1:0] target);
		isWrite = regWrEn && (regAddr == target);
	endfunction

	assign cfgPatEn = testCfg_reg[TC_PAT_EN];
	assign cfgInc = testCfg_reg[TC_INC];
	assign cfgPrbs = testCfg_reg[TC_PRBS];
	assign cfgFrame = testCfg_reg[TC_FRAME];

	// Configuration registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blackCal_reg <= BLACKCAL_RST;
			testCfg_reg <= TEST_CFG_RST[TC_W-1:0];
			patLow01_reg <= PAT_LOW01_RST;
			patLow23_reg <= PAT_LOW23_RST;
			patHigh_reg <= PAT_HIGH_RST[HIGH_FIELD_W-1:0];
		end
		else
		begin
			if (isWrite(ADDR_BLACKCAL))
				blackCal_reg <= regWrData;
			if (isWrite(ADDR_TEST_CFG))
				testCfg_reg <= regWrData[TC_W-1:0];
			if (isWrite(ADDR_PAT_LOW01))
				patLow01_reg <= regWrData;
			if (isWrite(ADDR_PAT_LOW23))
				patLow23_reg <= regWrData;
			if (isWrite(ADDR_PAT_HIGH))
				patHigh_reg <= regWrData[HIGH_FIELD_W-1:0];
		end
	end

	// Read mux
	always_comb
	begin
		unique case (regAddr)
			ADDR_BLACKCAL: rdValue = blackCal_reg;
			ADDR_CAL_FAULT: rdValue = {{(REG_W-NUM_CH){1'b0}}, calFault_reg};
			ADDR_RSVD_ONES: rdValue = RSVD_ONES_VAL;
			ADDR_TEST_CFG: rdValue = {{(REG_W-TC_W){1'b0}}, testCfg_reg};
			ADDR_PAT_LOW01: rdValue = patLow01_reg;
			ADDR_PAT_LOW23: rdValue = patLow23_reg;
			ADDR_PAT_HIGH: rdValue = {{(REG_W-HIGH_FIELD_W){1'b0}}, patHigh_reg};
			default: rdValue = RSVD_ZERO_VAL;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			regRdData <= RSVD_ZERO_VAL;
		else if (regRdEn)
			regRdData <= rdValue;
	end

	// Black sample counting per channel
	assign reqCount = CNT_W'(1) << blackCal_reg[BS_LSB +: BS_W];

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++)
		begin : g_cal
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					sampleCnt_reg[ch] <= '0;
				else if (blackCalStart)
					sampleCnt_reg[ch] <= '0;
				else if (blackSample[ch] && sampleCnt_reg[ch] != '1)
					sampleCnt_reg[ch] <= CNT_W'(sampleCnt_reg[ch] + 1'b1);
			end
			assign calFault_next[ch] = sampleCnt_reg[ch] < reqCount;
		end
	endgenerate

	// Fault flags are re-judged at the end of each calibration window
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			calFault_reg <= '0;
		else if (blackCalEnd)
			calFault_reg <= calFault_next;
	end

	// Pattern sources
	assign patActive = cfgPatEn || cfgPrbs;
	assign wordSlot = cfgFrame ? pixValid : 1'b1;
	assign lowBytes = {patLow23_reg, patLow01_reg};

	genvar ln;
	generate
		for (ln = 0; ln < NUM_LANES; ln++)
		begin : g_lane
			assign constWords[ln*WORD_W +: WORD_W] =
				{patHigh_reg[ln*HIGH_W +: HIGH_W], lowBytes[ln*LOW_W +: LOW_W]};
			dtc_lane_gen #(.SEED(PRBS_SEED ^ PRBS_W'(ln))) u_gen
			(
				.clk(clk),
				.rstn(rstn),
				.active(patActive),
				.incMode(cfgInc),
				.prbsMode(cfgPrbs),
				.advance(patActive && wordSlot),
				.loadValue(constWords[ln*WORD_W +: WORD_W]),
				.word(patWords[ln*WORD_W +: WORD_W])
			);
		end
	endgenerate

	// Output stage
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dataOut <= '0;
			dataValid <= 1'b0;
			frameOut <= 1'b0;
			lineOut <= 1'b0;
		end
		else if (!patActive)
		begin
			dataOut <= pixData;
			dataValid <= pixValid;
			frameOut <= frameIn;
			lineOut <= lineIn;
		end
		else if (cfgFrame)
		begin
			dataOut <= patWords;
			dataValid <= pixValid;
			frameOut <= frameIn;
			lineOut <= lineIn;
		end
		else
		begin
			dataOut <= patWords;
			dataValid <= 1'b1;
			frameOut <= 1'b0;
			lineOut <= 1'b0;
		end
	end

	fault_judge_a: assert property (@(posedge clk) disable iff (!rstn)
		blackCalEnd |=> calFault_reg == $past(calFault_next))
		else $error("Fault flags not updated at calibration end");

	fault_req_a: assert property (@(posedge clk) disable iff (!rstn)
		(blackCalEnd && sampleCnt_reg[0] >= (CNT_W'(1) << blackCal_reg[BS_LSB +: BS_W]))
		|=> !calFault_reg[0])
		else $error("Channel 0 flagged despite enough samples");

	fault_read_a: assert property (@(posedge clk) disable iff (!rstn)
		(regRdEn && regAddr == ADDR_CAL_FAULT && !blackCalEnd)
		|=> regRdData == {{(REG_W-NUM_CH){1'b0}}, calFault_reg})
		else $error("Fault word read mismatch");

	normal_pass_a: assert property (@(posedge clk) disable iff (!rstn)
		(!cfgPatEn && !cfgPrbs) |=> dataOut == $past(pixData) && dataValid == $past(pixValid))
		else $error("Image data not passed through");

	const_word_a: assert property (@(posedge clk) disable iff (!rstn)
		(cfgPatEn && !cfgInc && !cfgPrbs)
		|=> dataOut[2*WORD_W-1:WORD_W] == {$past(patHigh_reg[2*HIGH_W-1:HIGH_W]),
			$past(patLow01_reg[2*LOW_W-1:LOW_W])})
		else $error("Constant pattern on lane 1 wrong");

	ramp_step_a: assert property (@(posedge clk) disable iff (!rstn)
		(cfgPatEn && cfgInc && !cfgPrbs && !cfgFrame)[*3]
		|-> dataOut[WORD_W-1:0] == WORD_W'($past(dataOut[WORD_W-1:0]) + 1'b1))
		else $error("Ramp did not step by one");

	unframed_stream_a: assert property (@(posedge clk) disable iff (!rstn)
		(patActive && !cfgFrame) |=> dataValid && !frameOut && !lineOut)
		else $error("Unframed stream not continuous");

	framed_sync_a: assert property (@(posedge clk) disable iff (!rstn)
		(patActive && cfgFrame)
		|=> frameOut == $past(frameIn) && lineOut == $past(lineIn) && dataValid == $past(pixValid))
		else $error("Framed pattern lost sync structure");
endmodule

/* tb/dtc_pix_source.sv */
`timescale 1ns/1ps
module dtc_pix_source
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic frameOn,
	output logic [dtc_pkg::NUM_LANES*dtc_pkg::WORD_W-1:0] pixData,
	output logic pixValid,
	output logic frameIn,
	output logic lineIn
);
	import dtc_pkg::*;
	logic [WORD_W-1:0] cnt_reg;
	// Upstream source, distinct rising value per lane
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 10'h001;
	end
	assign pixData = {cnt_reg + 10'h003, cnt_reg + 10'h002, cnt_reg + 10'h001, cnt_reg};
	assign pixValid = cnt_reg[0];
	assign frameIn = frameOn;
	assign lineIn = frameOn & cnt_reg[1];
endmodule

/* tb/dtc_test_cal_status_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module dtc_test_cal_status_tb_top;
	import dtc_pkg::*;
	logic clk, rstn, regWrEn, regRdEn, blackCalStart, blackCalEnd, frameOn;
	logic pixValid, frameIn, lineIn, dataValid, frameOut, lineOut, pv, fi, li;
	logic [ADDR_W-1:0] regAddr;
	logic [REG_W-1:0] regWrData, regRdData;
	logic [NUM_CH-1:0] blackSample;
	logic [NUM_LANES*WORD_W-1:0] pixData, dataOut, prevPix;
	logic [WORD_W-1:0] w0;
	int error_cnt, checks_done, cyc;
	dtc_test_cal_status dut (.clk(clk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.blackCalStart(blackCalStart), .blackCalEnd(blackCalEnd), .blackSample(blackSample),
		.pixData(pixData), .pixValid(pixValid), .frameIn(frameIn), .lineIn(lineIn),
		.dataOut(dataOut), .dataValid(dataValid), .frameOut(frameOut), .lineOut(lineOut));
	dtc_pix_source src (.clk(clk), .rstn(rstn), .frameOn(frameOn), .pixData(pixData),
		.pixValid(pixValid), .frameIn(frameIn), .lineIn(lineIn));
	initial
	begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task complete_run();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	task wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		@(posedge clk) regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk) regWrEn <= 1'b0;
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
		@(posedge clk) regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk) regRdEn <= 1'b0;
		#1 `CHK(regRdData, e)
	endtask
	// Channel 0 gets n0 samples, the others eight
	task cal(input int n0, input logic [7:0] ef);
		@(posedge clk) blackCalStart <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk) blackCalStart <= 1'b0;
			blackSample <= (k < n0) ? 8'hFF : 8'hFE;
		end
		@(posedge clk) blackSample <= 8'h00;
		blackCalEnd <= 1'b1;
		@(posedge clk) blackCalEnd <= 1'b0;
		rd(ADDR_CAL_FAULT, {8'h00, ef});
	endtask
	// Valid, frame and line outputs one cycle behind their cause
	task stream(input int n);
		repeat (n)
		begin
			@(posedge clk) prevPix = pixData;
			pv = pixValid;
			fi = frameIn;
			li = lineIn;
			#1;
			`CHK({dataValid, frameOut, lineOut}, {pv, fi, li})
		end
	endtask
	initial
	begin
		rstn = 0;
		{regWrEn, regRdEn, blackCalStart, blackCalEnd, frameOn} = '0;
		regAddr = '0;
		regWrData = '0;
		blackSample = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd(ADDR_CAL_FAULT, 16'h0000);
		rd(ADDR_RSVD_A, 16'h0000);
		rd(ADDR_RSVD_C, 16'h0000);
		rd(ADDR_RSVD_ONES, 16'hFFFF);
		rd(ADDR_TEST_CFG, 16'h0000);
		rd(8'h00, 16'h0000);
		wr(ADDR_CAL_FAULT, 16'h00FF);
		rd(ADDR_CAL_FAULT, 16'h0000);
		wr(ADDR_TEST_CFG, 16'hFFF0);
		rd(ADDR_TEST_CFG, 16'h0000);
		frameOn <= 1'b1;
		stream(3);
		`CHK(dataOut, prevPix)
		wr(ADDR_PAT_HIGH, 16'hABE4);
		rd(ADDR_PAT_HIGH, 16'h00E4);
		wr(ADDR_TEST_CFG, 16'h0001);
		repeat (3) @(posedge clk);
		#1;
		for (int n = 0; n < NUM_LANES; n++)
			`CHK(dataOut[10*n +: 10], {n[1:0], n[7:0]})
		`CHK({dataValid, frameOut, lineOut}, 3'b100)
		wr(ADDR_TEST_CFG, 16'h0009);
		stream(4);
		wr(ADDR_PAT_LOW01, 16'h01FF);
		wr(ADDR_PAT_HIGH, 16'h0003);
		wr(ADDR_TEST_CFG, 16'h0003);
		@(posedge clk) #1 `CHK(dataOut[9:0], 10'h3FF)
		@(posedge clk) #1 `CHK(dataOut[9:0], 10'h000)
		@(posedge clk) #1 `CHK(dataOut[9:0], 10'h001)
		wr(ADDR_TEST_CFG, 16'h0005);
		@(posedge clk) #1 w0 = dataOut[9:0];
		`CHK(w0, PRBS_SEED[WORD_W-1:0])
		@(posedge clk) #1 `CHK(dataOut[9:0] != w0, 1'b1)
		`CHK(dataOut[9:0] != dataOut[19:10], 1'b1)
		wr(ADDR_TEST_CFG, 16'h0000);
		wr(ADDR_BLACKCAL, 16'h0308);
		cal(7, 8'h01);
		cal(8, 8'h00);
		wr(ADDR_BLACKCAL, 16'h0408);
		cal(8, 8'hFF);
		complete_run();
	end
endmodule
